// ---- src/regulator_startup_sequencer_pkg.sv ----
// constants, register map and timing for the regulator startup sequencer
// Functional notes
// - each regulator's power-up slot comes from its own 3-bit configuration field.
// - power-up slots are 0.5 ms apart, or 2.0 ms with spacing select set.
// - backup supply output turns on about 0.6 ms after valid input appears.
// - by default, processor reset releases 2.0 ms after the last regulator is up.
// - power-down waits 2.0 ms between successive slots.
// - default slots: linreg1/3 slot 1, buck3/linreg2 slot 2, buck2/ddr ref 3, buck1 4.
// - the control target address reads as 0x08.
// - processor reset held low until power-up ends, then released after 2..1024 ms.
// - power-down in descending slot order; all slots zero turns everything off at once.
// - power-up sequence runs from regulators-disabled to reset delay, ending at the last regulator.
`default_nettype none
package regulator_startup_sequencer_pkg;
    localparam int unsigned NUM_REGS = 7;
    localparam int unsigned SLOT_W = 3;
    // regulator index within the enable vector
    localparam int unsigned IDX_BUCK1 = 0;
    localparam int unsigned IDX_BUCK2 = 1;
    localparam int unsigned IDX_BUCK3 = 2;
    localparam int unsigned IDX_LINREG1 = 3;
    localparam int unsigned IDX_LINREG2 = 4;
    localparam int unsigned IDX_LINREG3 = 5;
    localparam int unsigned IDX_DDR_REF = 6;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UP_SLOTS = 8'h04;
    localparam logic [7:0] OFS_DOWN_SLOTS = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_TARGET_ADDR = 8'h10;
    // control register fields
    localparam int unsigned CTRL_SPACING_BIT = 0;
    localparam int unsigned CTRL_DELAY_LSB = 1;
    // status register fields
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_SLOT_LSB = 4;
    localparam int unsigned ST_EN_LSB = 8;
    localparam int unsigned ST_BACKUP_BIT = 16;
    localparam int unsigned ST_RESET_BIT = 17;
    // reset values: factory slot layout, buck1 in the lowest field
    localparam logic [20:0] UP_SLOTS_RESET = {3'h3, 3'h1, 3'h2, 3'h1, 3'h2, 3'h3, 3'h4};
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [6:0] TARGET_ADDR = 7'h08;
    // times in microseconds and the clock rate
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned BACKUP_DELAY_US = 600;
    localparam int unsigned SLOT_FAST_US = 500;
    localparam int unsigned SLOT_SLOW_US = 2000;
    localparam int unsigned DOWN_SPACING_US = 2000;
    localparam int unsigned RESET_BASE_US = 2000;
    localparam int unsigned BACKUP_DELAY_CYC = BACKUP_DELAY_US * CLK_MHZ;
    localparam int unsigned SLOT_FAST_CYC = SLOT_FAST_US * CLK_MHZ;
    localparam int unsigned SLOT_SLOW_CYC = SLOT_SLOW_US * CLK_MHZ;
    localparam int unsigned DOWN_SPACING_CYC = DOWN_SPACING_US * CLK_MHZ;
    localparam int unsigned RESET_BASE_CYC = RESET_BASE_US * CLK_MHZ;
    // reset delay code to shift of the 2 ms base: 2,4,8,16,32,128,512,1024 ms
    localparam logic [31:0] DELAY_SHIFT_TABLE = {4'h9, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
    typedef enum logic [2:0] {
        ST_NO_INPUT = 3'b000,
        ST_BACKUP_WAIT = 3'b001,
        ST_REGS_OFF = 3'b010,
        ST_POWER_UP = 3'b011,
        ST_RESET_DELAY = 3'b100,
        ST_RUN = 3'b101,
        ST_POWER_DOWN = 3'b110
    } seq_state_e;
endpackage
`default_nettype wire

// ---- src/regulator_startup_sequencer.sv ----
// slot based regulator power-up and power-down sequencer with apb registers
`timescale 1ns/1ps
`default_nettype none
module regulator_startup_sequencer
    import regulator_startup_sequencer_pkg::*;
#(
    parameter int unsigned backup_delay_cycles = BACKUP_DELAY_CYC,
    parameter int unsigned slot_fast_cycles = SLOT_FAST_CYC,
    parameter int unsigned slot_slow_cycles = SLOT_SLOW_CYC,
    parameter int unsigned down_spacing_cycles = DOWN_SPACING_CYC,
    parameter int unsigned reset_base_cycles = RESET_BASE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins from the board and the processor
    input wire logic input_valid,
    input wire logic power_on_input,
    // supply enables and processor reset
    output logic backup_supply_out,
    output logic [NUM_REGS-1:0] reg_enable,
    output logic processor_reset_out_n
);

    // pin synchronisers, first stage read only by the second
    logic valid_meta;
    logic valid_sync;
    logic pwr_meta;
    logic pwr_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_meta <= 1'b0;
            valid_sync <= 1'b0;
            pwr_meta <= 1'b0;
            pwr_sync <= 1'b0;
        end else begin
            valid_meta <= input_valid;
            valid_sync <= valid_meta;
            pwr_meta <= power_on_input;
            pwr_sync <= pwr_meta;
        end
    end

    // register file state
    logic [3:0] ctrl;
    logic [20:0] up_slots;
    logic [20:0] down_slots;
    logic [31:0] rdata_q;
    logic slverr_q;
    logic [3:0] next_ctrl;
    logic [20:0] next_up_slots;
    logic [20:0] next_down_slots;
    logic [31:0] next_rdata;
    logic next_slverr;

    // sequencer state
    seq_state_e state;
    seq_state_e next_state;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic [SLOT_W-1:0] slot;
    logic [SLOT_W-1:0] next_slot;
    logic [NUM_REGS-1:0] en;
    logic [NUM_REGS-1:0] next_en;
    logic backup;
    logic next_backup;
    logic rst_n;
    logic next_rst_n;

    // per regulator slot fields and derived masks
    logic [SLOT_W-1:0] up_slot [NUM_REGS];
    logic [SLOT_W-1:0] down_slot [NUM_REGS];
    logic [SLOT_W-1:0] max_up;
    logic [SLOT_W-1:0] max_down;
    logic [NUM_REGS-1:0] up_now_mask;
    logic [NUM_REGS-1:0] down_now_mask;
    logic [31:0] slot_spacing;
    logic [31:0] reset_delay;
    logic [3:0] delay_shift;

    logic setup_phase;
    logic access_phase;
    logic reg_hit;
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;

    // split the packed slot words and find the highest slot in use
    always_comb begin
        max_up = '0;
        max_down = '0;
        up_now_mask = '0;
        down_now_mask = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            up_slot[i] = up_slots[SLOT_W*i +: SLOT_W];
            down_slot[i] = down_slots[SLOT_W*i +: SLOT_W];
            if (up_slot[i] > max_up) begin
                max_up = up_slot[i];
            end
            if (down_slot[i] > max_down) begin
                max_down = down_slot[i];
            end
            // zero slot never matches a running slot, so it is left alone
            up_now_mask[i] = (up_slot[i] == slot) && (slot != '0);
            // regulators at or above the current slot go off, descending order
            down_now_mask[i] = (down_slot[i] >= slot);
        end
    end

    // spacing and reset release delay from the control bits
    always_comb begin
        slot_spacing = ctrl[CTRL_SPACING_BIT] ? 32'(slot_slow_cycles) : 32'(slot_fast_cycles);
        delay_shift = DELAY_SHIFT_TABLE[4*ctrl[CTRL_DELAY_LSB +: 3] +: 4];
        // code zero gives the plain 2 ms base
        reset_delay = 32'(reset_base_cycles) << delay_shift;
    end

    // sequencer next state
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_slot = slot;
        next_en = en;
        next_backup = backup;
        next_rst_n = rst_n;
        case (state)
            ST_NO_INPUT: begin
                if (valid_sync) begin
                    next_state = ST_BACKUP_WAIT;
                    next_timer = 32'(backup_delay_cycles);
                end
            end
            ST_BACKUP_WAIT: begin
                if (timer > 32'h1) begin
                    next_timer = timer - 32'h1;
                end else begin
                    // backup supply first, before any sequenced regulator
                    next_backup = 1'b1;
                    next_state = ST_REGS_OFF;
                end
            end
            ST_REGS_OFF: begin
                next_rst_n = 1'b0;
                if (pwr_sync) begin
                    next_state = ST_POWER_UP;
                    next_slot = 3'h1;
                    next_timer = '0;
                end
            end
            ST_POWER_UP: begin
                if (max_up == '0) begin
                    next_state = ST_RESET_DELAY;
                    next_timer = reset_delay;
                end else if (timer == '0) begin
                    next_en = en | up_now_mask;
                    if (slot >= max_up) begin
                        // done as soon as the last slot is enabled
                        next_state = ST_RESET_DELAY;
                        next_timer = reset_delay;
                    end else begin
                        next_slot = slot + 3'h1;
                        next_timer = slot_spacing - 32'h1;
                    end
                end else begin
                    next_timer = timer - 32'h1;
                end
            end
            ST_RESET_DELAY: begin
                if (!pwr_sync) begin
                    next_state = ST_POWER_DOWN;
                    next_slot = max_down;
                    next_timer = '0;
                end else if (timer > 32'h1) begin
                    next_timer = timer - 32'h1;
                end else begin
                    next_rst_n = 1'b1;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!pwr_sync) begin
                    next_rst_n = 1'b0;
                    next_state = ST_POWER_DOWN;
                    next_slot = max_down;
                    next_timer = '0;
                end
            end
            ST_POWER_DOWN: begin
                next_rst_n = 1'b0;
                if (slot == '0) begin
                    // all zero or the last step: whatever is left goes off at once
                    next_en = '0;
                    next_state = ST_REGS_OFF;
                end else if (timer == '0) begin
                    next_en = en & ~down_now_mask;
                    next_slot = slot - 3'h1;
                    next_timer = (slot == 3'h1) ? '0 : 32'(down_spacing_cycles) - 32'h1;
                end else begin
                    next_timer = timer - 32'h1;
                end
            end
            default: begin
                next_state = ST_NO_INPUT;
            end
        endcase
        // losing the input supply drops everything regardless of state
        if (!valid_sync) begin
            next_state = ST_NO_INPUT;
            next_en = '0;
            next_backup = 1'b0;
            next_rst_n = 1'b0;
            next_timer = '0;
            next_slot = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_NO_INPUT;
            timer <= '0;
            slot <= '0;
            en <= '0;
            backup <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            slot <= next_slot;
            en <= next_en;
            backup <= next_backup;
            rst_n <= next_rst_n;
        end
    end

    // address decode for mapped words
    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_UP_SLOTS, OFS_DOWN_SLOTS, OFS_STATUS, OFS_TARGET_ADDR: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    end

    // register writes at the access edge, read data captured in setup so it is ready with no wait
    always_comb begin
        next_ctrl = ctrl;
        next_up_slots = up_slots;
        next_down_slots = down_slots;
        next_rdata = rdata_q;
        next_slverr = slverr_q;
        if (access_phase && pwrite) begin
            case (paddr)
                OFS_CTRL: next_ctrl = pwdata[3:0];
                OFS_UP_SLOTS: next_up_slots = pwdata[20:0];
                OFS_DOWN_SLOTS: next_down_slots = pwdata[20:0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (setup_phase) begin
            next_slverr = !reg_hit;
            case (paddr)
                OFS_CTRL: next_rdata = {28'h0, ctrl};
                OFS_UP_SLOTS: next_rdata = {11'h0, up_slots};
                OFS_DOWN_SLOTS: next_rdata = {11'h0, down_slots};
                OFS_STATUS: begin
                    next_rdata = '0;
                    next_rdata[ST_STATE_LSB +: 3] = state;
                    next_rdata[ST_SLOT_LSB +: SLOT_W] = slot;
                    next_rdata[ST_EN_LSB +: NUM_REGS] = en;
                    next_rdata[ST_BACKUP_BIT] = backup;
                    next_rdata[ST_RESET_BIT] = rst_n;
                end
                OFS_TARGET_ADDR: next_rdata = {25'h0, TARGET_ADDR};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // down slots start as a mirror of the up slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            up_slots <= UP_SLOTS_RESET;
            down_slots <= UP_SLOTS_RESET;
            rdata_q <= '0;
            slverr_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            up_slots <= next_up_slots;
            down_slots <= next_down_slots;
            rdata_q <= next_rdata;
            slverr_q <= next_slverr;
        end
    end

    // outputs
    assign pready = 1'b1;
    assign pslverr = access_phase && slverr_q;
    assign prdata = rdata_q;
    assign backup_supply_out = backup;
    assign reg_enable = en;
    assign processor_reset_out_n = rst_n;

endmodule
`default_nettype wire

// ---- testbench/sequencer_monitor.sv ----
// port checker for the regulator startup sequencer
`timescale 1ns/1ps
`default_nettype none
module sequencer_monitor
    import regulator_startup_sequencer_pkg::*;
#(
    parameter int unsigned backup_delay_cycles = 20,
    parameter int unsigned slot_fast_cycles = 10,
    parameter int unsigned slot_slow_cycles = 40,
    parameter int unsigned down_spacing_cycles = 40,
    parameter int unsigned reset_base_cycles = 30
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic input_valid,
    input wire logic power_on_input,
    input wire logic backup_supply_out,
    input wire logic [6:0] reg_enable,
    input wire logic processor_reset_out_n
);
    logic [6:0] prev;
    logic [3:0] ctrl_q;
    logic last_drop;
    int unsigned cnt;
    int unsigned vcnt;
    wire logic chg = reg_enable != prev;
    wire logic rise = chg && ((prev & ~reg_enable) == 7'h00);
    wire logic drop = chg && ((reg_enable & ~prev) == 7'h00);
    wire logic [31:0] rd_exp = reset_base_cycles << DELAY_SHIFT_TABLE[4*ctrl_q[3:1] +: 4];
    // cycles since the last enable change, so every spacing is measured from one reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 7'h00;
            ctrl_q <= 4'h0;
            last_drop <= 1'b0;
            cnt <= 0;
            vcnt <= 0;
        end else begin
            prev <= reg_enable;
            cnt <= chg ? 1 : cnt + 1;
            vcnt <= input_valid ? vcnt + 1 : 0;
            if (chg) last_drop <= drop;
            if (psel && penable && pwrite && paddr == OFS_CTRL) ctrl_q <= pwdata[3:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence target_setup;
        psel && !penable && !pwrite && paddr == OFS_TARGET_ADDR;
    endsequence
    sequence target_access;
        psel && penable;
    endsequence
    backup_first_a: assert property (
        reg_enable != 7'h00 |-> backup_supply_out) else $error("regulator on without backup supply");
    backup_delay_a: assert property (
        $rose(backup_supply_out) |-> vcnt >= backup_delay_cycles && vcnt <= backup_delay_cycles + 8)
        else $error("backup supply delay wrong");
    novalid_off_a: assert property (
        $fell(input_valid) |-> ##[1:6] (reg_enable == 7'h00 && !backup_supply_out && !processor_reset_out_n))
        else $error("outputs stay on without input");
    up_spacing_a: assert property (
        rise && prev != 7'h00 |-> cnt == (ctrl_q[0] ? slot_slow_cycles : slot_fast_cycles))
        else $error("power-up slot spacing wrong");
    down_spacing_a: assert property (
        drop && last_drop && input_valid |-> cnt == down_spacing_cycles) else $error("power-down spacing wrong");
    reset_delay_a: assert property (
        $rose(processor_reset_out_n) |-> cnt == rd_exp) else $error("reset release delay wrong");
    reset_needs_regs_a: assert property (
        processor_reset_out_n |-> reg_enable != 7'h00 && backup_supply_out) else $error("reset released too early");
    reset_on_down_a: assert property (
        processor_reset_out_n && !power_on_input |-> ##[1:6] !processor_reset_out_n)
        else $error("reset not taken on power down");
    target_addr_a: assert property (
        target_setup ##1 target_access |-> prdata == {25'h0, TARGET_ADDR}) else $error("target address wrong");
    unmapped_err_a: assert property (
        psel && penable && paddr > OFS_TARGET_ADDR |-> pslverr && pready) else $error("no error on unmapped");
endmodule
`default_nettype wire

// ---- testbench/processor_model.sv ----
// application processor model: drives the power-on request
`timescale 1ns/1ps
`default_nettype none
module processor_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench request
    input wire logic want_on,
    // power-on request pin
    output logic power_on_input
);
    // request moves only after an edge and stays steady through a whole sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) power_on_input <= 1'b0;
        else power_on_input <= want_on;
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the regulator startup sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import regulator_startup_sequencer_pkg::*;
    localparam logic [20:0] DEF = {3'h3, 3'h1, 3'h2, 3'h1, 3'h2, 3'h3, 3'h4};
    localparam logic [20:0] ALT = {3'h3, 3'h1, 3'h2, 3'h1, 3'h2, 3'h3, 3'h0};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, input_valid = 0, want_on = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic pready, pslverr, power_on_input, backup_supply_out, processor_reset_out_n, err;
    logic [6:0] reg_enable;
    int fail_count = 0, checks_done = 0;
    // 200 MHz clock
    initial forever #2.5 pclk = ~pclk;
    regulator_startup_sequencer #(.backup_delay_cycles(20), .slot_fast_cycles(10), .slot_slow_cycles(40),
        .down_spacing_cycles(40), .reset_base_cycles(30)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .input_valid, .power_on_input, .backup_supply_out,
        .reg_enable, .processor_reset_out_n);
    processor_model cpu (.pclk, .presetn, .want_on, .power_on_input);
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // regulators whose slot lies in lo..hi
    function automatic logic [6:0] sel(input logic [20:0] sl, input int lo, input int hi);
        for (int i = 0; i < 7; i++) sel[i] = sl[3*i +: 3] >= lo && sl[3*i +: 3] <= hi;
    endfunction
    // waits for the next enable change; a gap of zero skips the timing check
    task automatic wait_regs(input logic [6:0] exp, input int gap);
        logic [6:0] last;
        int n;
        last = reg_enable;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (reg_enable === last && n < 2000);
        check({25'h0, reg_enable}, {25'h0, exp});
        if (gap > 0) check(32'(n), 32'(gap));
    endtask
    task automatic run_seq(input logic [20:0] up, input logic [20:0] dn, input logic [3:0] ctl, input int sp,
        input int rdl);
        logic [6:0] m;
        int n;
        apb(1'b1, OFS_UP_SLOTS, {11'h0, up});
        apb(1'b1, OFS_DOWN_SLOTS, {11'h0, dn});
        apb(1'b1, OFS_CTRL, {28'h0, ctl});
        want_on <= 1'b1;
        for (int s = 1; s < 8; s++)
            if (sel(up, 1, s) != sel(up, 1, s - 1)) wait_regs(sel(up, 1, s), s > 1 ? sp : 0);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (processor_reset_out_n !== 1'b1 && n < 5000);
        check(32'(n), 32'(rdl));
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd & 32'h0003ff07, {14'h0, 2'b11, 1'b0, sel(up, 1, 7), 8'h05});
        want_on <= 1'b0;
        m = sel(up, 1, 7);
        n = 0;
        for (int s = 7; s > 0; s--)
            if ((m & ~sel(dn, s, s)) != m) begin
                m = m & ~sel(dn, s, s);
                wait_regs(m, n > 0 ? 40 : 0);
                n++;
            end
        if (m != 7'h00) wait_regs(7'h00, 0);
        check({31'h0, processor_reset_out_n}, 32'h0);
    endtask
    // main sequence: reset values, three configurations, loss of input mid power-up
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFS_UP_SLOTS, 32'h0);
        check(rd, {11'h0, DEF});
        apb(1'b0, OFS_DOWN_SLOTS, 32'h0);
        check(rd, {11'h0, DEF});
        apb(1'b1, OFS_TARGET_ADDR, 32'hff);
        apb(1'b0, OFS_TARGET_ADDR, 32'h0);
        check(rd, 32'h8);
        apb(1'b0, 8'h14, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        input_valid <= 1'b1;
        repeat (10) @(posedge pclk);
        check({31'h0, backup_supply_out}, 32'h0);
        repeat (20) @(posedge pclk);
        check({24'h0, backup_supply_out, reg_enable}, 32'h80);
        run_seq(DEF, DEF, 4'h0, 10, 30);
        run_seq(ALT, 21'h0, 4'h3, 40, 60);
        // delay code 5 is the first step where the table is no longer linear: 128 ms is 64 times the base
        run_seq(DEF, DEF, 4'ha, 10, 1920);
        want_on <= 1'b1;
        wait_regs(sel(ALT, 1, 1), 0);
        // the supply is dropped on a rising edge, as every other design input is
        @(posedge pclk);
        input_valid <= 1'b0;
        repeat (8) @(posedge pclk);
        check({24'h0, backup_supply_out, reg_enable}, 32'h0);
        stop_test;
    end
    // watchdog against a hang
    initial begin
        #100000;
        fail_count++;
        stop_test;
    end
endmodule
bind regulator_startup_sequencer sequencer_monitor #(.backup_delay_cycles(backup_delay_cycles),
    .slot_fast_cycles(slot_fast_cycles), .slot_slow_cycles(slot_slow_cycles),
    .down_spacing_cycles(down_spacing_cycles), .reset_base_cycles(reset_base_cycles)) mon (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .input_valid, .power_on_input,
    .backup_supply_out, .reg_enable, .processor_reset_out_n);
`default_nettype wire
